// File: include/tsd_pkg.sv
// constants, field layouts and state types of the synth divider core
// assumes a single 40 MHz system clock sampling every pin
//
// Overview of operation
// RL1: main reference divider is 8 bits, ratios 2 to 255
// RL2: both auxiliary reference dividers are 10 bits, ratios 2 to 1023
// RL3: main feedback value: 15 upper bits integer, 4 lower bits numerator
// RL4: main ratio 80..32767 high band, 40..16383 low band
// RL5: 4-bit denominator picks fractional modulus, step 1/2 to 1/16; code sets modulus denominator+1, so 1 to 16, step 1 to 1/16
// RL6: 4-bit accumulator overflow adds one extra oscillator cycle
// RL7: auxiliary feedback dividers are 13-bit integer, 56 to 8191
// RL8: feedback dividers count own prescaler, reference dividers the reference
// RL9: polarity bit swaps pump-up and pump-down per channel
// RL10: main pump current field picks 100, 400, 700 or 900 uA
// RL11: doubler bit keeps reference block powered, pins cannot override
// RL12: data shifts MSB first on rising serial clock while latch low
// RL13: last three bits address; latch rise copies word to that bank
// RL14: address zero loads preset values into all four banks
// RL15: digital lock rises after five cycles with error under 15 ns
// RL16: digital lock falls once error exceeds 30 ns in one cycle
// RL17: analog lock pin low while any active channel pumps
// RL18: lock pin may carry divider or fastlock counter outputs instead
// RL19: low enable pin powers channel down; high pin defers to bit
// RL20: powered-down channel resets dividers, pump and detector float
// RL21: on power return feedback restarts aligned with reference
// RL22: reference block off when all pins low or all bits set
// RL23: 4-bit select picks lock mode, counter output, fastlock or test
// RL24: polarity one means rising tuning slope, zero falling slope
// RL25: serial clock while latch high changes nothing
package tsd_pkg;

  localparam logic [2:0] ADDR_PRESET = 3'h0;
  localparam logic [2:0] ADDR_IFR = 3'h1;
  localparam logic [2:0] ADDR_IFN = 3'h2;
  localparam logic [2:0] ADDR_RFR = 3'h3;
  localparam logic [2:0] ADDR_RFN = 3'h4;

  // synchroniser bit map
  localparam int SY_CLK = 0;
  localparam int SY_DAT = 1;
  localparam int SY_LE = 2;
  localparam int SY_REF = 3;
  localparam int SY_FB = 4;
  localparam int SY_EN = 7;
  localparam int SY_W = 10;
  localparam int NCH = 3;

  // timing, in picoseconds and cycles
  localparam int CLK_PS = 25000;
  localparam int ERR_IN_PS = 15000;
  localparam int ERR_OUT_PS = 30000;
  localparam int ERR_IN_RAW = (ERR_IN_PS + CLK_PS - 1) / CLK_PS;
  localparam int ERR_OUT_RAW = ERR_OUT_PS / CLK_PS;
  localparam logic [3:0] ERR_IN_CYC =
    4'(ERR_IN_RAW < 1 ? 1 : ERR_IN_RAW);
  localparam logic [3:0] ERR_OUT_CYC =
    4'(ERR_OUT_RAW < 1 ? 1 : ERR_OUT_RAW);
  localparam logic [2:0] LOCK_RUNS = 3'h5;

  typedef enum logic [3:0] {
    LK_DIGITAL = 4'h0,
    LK_ANALOG = 4'h1,
    LK_RECV_R = 4'h8,
    LK_RECV_N = 4'h9,
    LK_XMIT_R = 4'hA,
    LK_XMIT_N = 4'hB,
    LK_MAIN_R = 4'hC,
    LK_MAIN_N = 4'hD,
    LK_FASTLOCK = 4'hE,
    LK_FRAC_TEST = 4'hF
  } tsd_lock_e;

  typedef enum logic [1:0] {
    ICP_100UA = 2'h0,
    ICP_400UA = 2'h1,
    ICP_700UA = 2'h2,
    ICP_900UA = 2'h3
  } tsd_icp_e;

  typedef struct packed {
    logic [9:0] tx_r;
    logic tx_pol;
    logic tx_rst;
    tsd_lock_e ld_sel;
    logic [9:0] rx_r;
    logic rx_pol;
    logic rx_rst;
    logic spare;
  } tsd_ifr_s;

  typedef struct packed {
    logic [9:0] tx_b;
    logic [2:0] tx_a;
    logic xmit_powerdown_bit;
    logic [9:0] rx_b;
    logic [2:0] rx_a;
    logic recv_powerdown_bit;
    logic spare;
  } tsd_ifn_s;

  typedef struct packed {
    logic [7:0] r_cnt;
    logic [6:0] fl_count;
    logic [7:0] spare;
    logic dbl;
    tsd_icp_e icpo;
    logic pol;
    logic rst;
    logic spare0;
  } tsd_rfr_s;

  typedef struct packed {
    logic [14:0] n_int;
    logic [3:0] n_frac;
    logic [3:0] frac_d;
    logic [2:0] test;
    logic high_band;
    logic pwdn;
    logic spare;
  } tsd_rfn_s;

  localparam tsd_ifr_s IFR_PRESET = 29'h0540054;
  localparam tsd_ifn_s IFN_PRESET = 29'h03800E0;
  localparam tsd_rfr_s RFR_PRESET = 29'h1400004;
  localparam tsd_rfn_s RFN_PRESET = 29'h0140004;

  typedef struct packed {
    logic [9:0] rcnt;
    logic [14:0] ncnt;
    logic rtgl;
    logic ntgl;
    logic up;
    logic dn;
    logic on;
    logic [3:0] err;
    logic [2:0] good;
    logic lock;
    logic pu;
    logic pd;
    logic poe;
  } tsd_ch_s;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic [SY_W-1:0] prev;
    logic [31:0] sr;
    tsd_ifr_s ifr;
    tsd_ifn_s ifn;
    tsd_rfr_s rfr;
    tsd_rfn_s rfn;
    logic [3:0] acc;
    logic ovf;
    logic [6:0] fl;
    logic ref_on;
    logic lk_out;
    logic lk_oe;
    tsd_ch_s [NCH-1:0] ch;
  } tsd_st_s;

endpackage

// File: verilog/tsd_core.sv
// three-channel synth divider core: serial port, banks, dividers,
// detectors, lock mux and power control
// assumes all pins asynchronous to sys_clk and far slower than it
`timescale 1ns/1ps
module tsd_core import tsd_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_enable,
  input wire logic ref_in,
  input wire logic main_fb_in,
  input wire logic recv_fb_in,
  input wire logic xmit_fb_in,
  input wire logic main_enable_pin,
  input wire logic recv_enable_pin,
  input wire logic xmit_enable_pin,
  output logic [NCH-1:0] pump_output_up,
  output logic [NCH-1:0] pump_output_dn,
  output logic [NCH-1:0] pump_output_oe,
  output tsd_icp_e main_pump_current_sel,
  output logic doubler_on,
  output logic ref_block_on,
  output logic main_high_band,
  output logic lock_out,
  output logic lock_oe
);

  tsd_st_s r_reg;
  tsd_st_s r_next;

  logic [SY_W-1:0] rise;
  logic ref_edge;
  logic le_rise;
  logic [NCH-1:0] en;
  logic [NCH-1:0] pw;
  logic [NCH-1:0] pol;
  logic [NCH-1:0] rst;
  logic [NCH-1:0] on;
  logic [9:0] rdiv [NCH];
  logic [14:0] ndiv [NCH];
  logic [NCH-1:0] rpul;
  logic [NCH-1:0] npul;
  logic [NCH-1:0] ev;
  logic [4:0] frac_sum;
  logic [4:0] frac_mod;

  assign rise = r_reg.sync2 & ~r_reg.prev;
  // reference counters advance on the falling edge
  assign ref_edge = ~r_reg.sync2[SY_REF] & r_reg.prev[SY_REF]
    & r_reg.ref_on;
  assign le_rise = rise[SY_LE];
  assign en = r_reg.sync2[SY_EN+NCH-1:SY_EN];
  assign pw = {r_reg.ifn.xmit_powerdown_bit, r_reg.ifn.recv_powerdown_bit, r_reg.rfn.pwdn};
  assign pol = {r_reg.ifr.tx_pol, r_reg.ifr.rx_pol, r_reg.rfr.pol};
  assign rst = {r_reg.ifr.tx_rst, r_reg.ifr.rx_rst, r_reg.rfr.rst};
  assign on = en & ~pw; // RL19

  assign rdiv[0] = {2'h0, r_reg.rfr.r_cnt}; // RL1
  assign rdiv[1] = r_reg.ifr.rx_r; // RL2
  assign rdiv[2] = r_reg.ifr.tx_r; // RL2
  // overflow stretches the main period by one cycle
  assign ndiv[0] = r_reg.rfn.n_int + {14'h0, r_reg.ovf}; // RL3
  assign ndiv[1] = {2'h0, r_reg.ifn.rx_b, r_reg.ifn.rx_a}; // RL7
  assign ndiv[2] = {2'h0, r_reg.ifn.tx_b, r_reg.ifn.tx_a}; // RL7

  assign frac_sum = {1'b0, r_reg.acc} + {1'b0, r_reg.rfn.n_frac};
  assign frac_mod = {1'b0, r_reg.rfn.frac_d} + 5'h01; // RL5

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // terminal counts, on the divider's own input edge
    assign rpul[i] = ref_edge
      && (r_reg.ch[i].rcnt + 10'h001 == rdiv[i]); // RL8
    assign npul[i] = rise[SY_FB+i]
      && (r_reg.ch[i].ncnt + 15'h0001 == ndiv[i]); // RL8
    assign ev[i] = (r_reg.ch[i].up | rpul[i])
      & (r_reg.ch[i].dn | npul[i]);
    assign pump_output_up[i] = r_reg.ch[i].pu;
    assign pump_output_dn[i] = r_reg.ch[i].pd;
    assign pump_output_oe[i] = r_reg.ch[i].poe;
  end

  assign main_pump_current_sel = r_reg.rfr.icpo; // RL10
  assign doubler_on = r_reg.rfr.dbl; // RL11
  assign ref_block_on = r_reg.ref_on;
  assign main_high_band = r_reg.rfn.high_band; // RL4
  assign lock_out = r_reg.lk_out;
  assign lock_oe = r_reg.lk_oe;

  always_comb begin
    logic lv;
    logic od;
    logic all_lock;
    logic any_pump;
    lv = 1'b1;
    od = 1'b1;
    all_lock = 1'b1;
    any_pump = 1'b0;
    r_next = r_reg;
    r_next.sync1 = {xmit_enable_pin, recv_enable_pin, main_enable_pin,
      xmit_fb_in, recv_fb_in, main_fb_in, ref_in, latch_enable,
      ser_data, ser_clk};
    r_next.sync2 = r_reg.sync1;
    r_next.prev = r_reg.sync2;

    // serial port stays live in every power state
    if (rise[SY_CLK] && !r_reg.sync2[SY_LE]) begin
      r_next.sr = {r_reg.sr[30:0], r_reg.sync2[SY_DAT]}; // RL12 RL25
    end
    if (le_rise) begin
      case (r_reg.sr[2:0]) // RL13
        ADDR_PRESET: begin
          r_next.ifr = IFR_PRESET; // RL14
          r_next.ifn = IFN_PRESET;
          r_next.rfr = RFR_PRESET;
          r_next.rfn = RFN_PRESET;
        end
        ADDR_IFR: r_next.ifr = r_reg.sr[31:3];
        ADDR_IFN: r_next.ifn = r_reg.sr[31:3];
        ADDR_RFR: r_next.rfr = r_reg.sr[31:3];
        ADDR_RFN: r_next.rfn = r_reg.sr[31:3];
        default: r_next.sr = r_reg.sr;
      endcase
    end

    // doubler keeps the block alive whatever the pins say
    r_next.ref_on = r_reg.rfr.dbl
      | ~((~|en) | (&pw)); // RL11 RL22

    for (int i = 0; i < NCH; i++) begin
      r_next.ch[i].on = on[i];
      if (!on[i]) begin
        // dividers held at zero, pump and detector floating
        r_next.ch[i] = '0; // RL20
        r_next.ch[i].lock = 1'b1;
      end else if (rst[i]) begin
        r_next.ch[i].rcnt = 10'h000;
        r_next.ch[i].ncnt = 15'h0000;
        r_next.ch[i].up = 1'b0;
        r_next.ch[i].dn = 1'b0;
        r_next.ch[i].err = 4'h0;
        r_next.ch[i].poe = 1'b0;
      end else begin
        if (ref_edge) begin
          r_next.ch[i].rcnt = rpul[i] ? 10'h000
            : r_reg.ch[i].rcnt + 10'h001;
        end
        if (rise[SY_FB+i]) begin
          r_next.ch[i].ncnt = npul[i] ? 15'h0000
            : r_reg.ch[i].ncnt + 15'h0001;
        end
        r_next.ch[i].rtgl = r_reg.ch[i].rtgl ^ rpul[i];
        r_next.ch[i].ntgl = r_reg.ch[i].ntgl ^ npul[i];
        if (r_reg.ch[i].up ^ r_reg.ch[i].dn) begin
          if (r_reg.ch[i].err != 4'hF) begin
            r_next.ch[i].err = r_reg.ch[i].err + 4'h1;
          end
        end
        if (ev[i]) begin
          r_next.ch[i].up = 1'b0;
          r_next.ch[i].dn = 1'b0;
          r_next.ch[i].err = 4'h0;
          if (r_reg.ch[i].err > ERR_OUT_CYC) begin
            r_next.ch[i].lock = 1'b0; // RL16
            r_next.ch[i].good = 3'h0;
          end else if (r_reg.ch[i].err < ERR_IN_CYC) begin
            if (r_reg.ch[i].good + 3'h1 >= LOCK_RUNS) begin
              r_next.ch[i].lock = 1'b1; // RL15
            end else begin
              r_next.ch[i].good = r_reg.ch[i].good + 3'h1;
            end
          end else if (!r_reg.ch[i].lock) begin
            r_next.ch[i].good = 3'h0;
          end
        end else begin
          r_next.ch[i].up = r_reg.ch[i].up | rpul[i];
          r_next.ch[i].dn = r_reg.ch[i].dn | npul[i];
        end
        if (!r_reg.ch[i].on) begin
          // fresh start: both dividers left zero together
          r_next.ch[i].lock = 1'b0; // RL21
          r_next.ch[i].good = 3'h0;
        end
        // one means rising slope: lead of reference pumps up
        r_next.ch[i].pu = pol[i] ? r_reg.ch[i].up
          : r_reg.ch[i].dn; // RL9 RL24
        r_next.ch[i].pd = pol[i] ? r_reg.ch[i].dn
          : r_reg.ch[i].up; // RL9 RL24
        r_next.ch[i].poe = r_reg.ch[i].up | r_reg.ch[i].dn;
      end
      all_lock = all_lock & r_reg.ch[i].lock;
      any_pump = any_pump | (r_reg.ch[i].on
        & (r_reg.ch[i].up | r_reg.ch[i].dn));
    end

    // fractional accumulator on the main channel
    if (!on[0]) begin
      r_next.acc = 4'h0;
      r_next.ovf = 1'b0;
    end else if (npul[0]) begin
      if (frac_sum >= frac_mod) begin
        r_next.acc = 4'(frac_sum - frac_mod); // RL6
        r_next.ovf = 1'b1;
      end else begin
        r_next.acc = frac_sum[3:0];
        r_next.ovf = 1'b0;
      end
    end

    // fastlock timeout: main comparison cycles after a main N load
    if (le_rise && r_reg.sr[2:0] == ADDR_RFN) begin
      r_next.fl = r_reg.rfr.fl_count;
    end else if (rpul[0] && r_reg.fl != 7'h00) begin
      r_next.fl = r_reg.fl - 7'h01;
    end

    case (r_reg.ifr.ld_sel) // RL23
      LK_DIGITAL: lv = all_lock; // RL15
      LK_ANALOG: lv = ~any_pump; // RL17
      LK_RECV_R: begin
        lv = r_reg.ch[1].rtgl; // RL18
        od = 1'b0;
      end
      LK_RECV_N: begin
        lv = r_reg.ch[1].ntgl;
        od = 1'b0;
      end
      LK_XMIT_R: begin
        lv = r_reg.ch[2].rtgl;
        od = 1'b0;
      end
      LK_XMIT_N: begin
        lv = r_reg.ch[2].ntgl;
        od = 1'b0;
      end
      LK_MAIN_R: begin
        lv = r_reg.ch[0].rtgl;
        od = 1'b0;
      end
      LK_MAIN_N: begin
        lv = r_reg.ch[0].ntgl;
        od = 1'b0;
      end
      LK_FASTLOCK: begin
        lv = |r_reg.fl; // RL18
        od = 1'b0;
      end
      LK_FRAC_TEST: begin
        lv = r_reg.ovf;
        od = 1'b0;
      end
      default: lv = 1'b1;
    endcase
    // open drain only pulls low
    r_next.lk_out = od ? 1'b0 : lv;
    r_next.lk_oe = od ? ~lv : 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_reg <= '0;
      // latch pin idles high: no false latch edge after reset
      r_reg.sync1[SY_LE] <= 1'b1;
      r_reg.sync2[SY_LE] <= 1'b1;
      r_reg.prev[SY_LE] <= 1'b1;
      r_reg.ifr <= IFR_PRESET;
      r_reg.ifn <= IFN_PRESET;
      r_reg.rfr <= RFR_PRESET;
      r_reg.rfn <= RFN_PRESET;
    end else begin
      r_reg <= r_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_shift_hold: assert property ( // RL25
    rise[SY_CLK] && r_reg.sync2[SY_LE] && !le_rise
    |=> $stable(r_reg.sr) && $stable(r_reg.ifr))
    else $error("shift moved while latch high");

  chk_shift_msb_first: assert property ( // RL12
    rise[SY_CLK] && !r_reg.sync2[SY_LE]
    |=> r_reg.sr == {$past(r_reg.sr[30:0]),
      $past(r_reg.sync2[SY_DAT])})
    else $error("serial bit not shifted in at lsb");

  chk_latch_bank: assert property ( // RL13
    le_rise && r_reg.sr[2:0] == ADDR_RFR
    |=> r_reg.rfr == $past(r_reg.sr[31:3]))
    else $error("addressed bank not loaded");

  chk_preset_all: assert property ( // RL14
    le_rise && r_reg.sr[2:0] == ADDR_PRESET
    |=> r_reg.ifr == IFR_PRESET && r_reg.ifn == IFN_PRESET
      && r_reg.rfr == RFR_PRESET && r_reg.rfn == RFN_PRESET)
    else $error("preset did not reach all banks");

  chk_pin_power: assert property ( // RL19
    !en[1] |=> !r_reg.ch[1].on)
    else $error("channel on with enable pin low");

  chk_down_float: assert property ( // RL20
    !on[2] ##1 !on[2] |=> !r_reg.ch[2].poe
      && r_reg.ch[2].rcnt == 10'h000 && r_reg.ch[2].ncnt == 15'h0000)
    else $error("powered-down channel still active");

  chk_lock_rise: assert property ( // RL15
    $rose(r_reg.ch[0].lock) && r_reg.ch[0].on
    |-> $past(r_reg.ch[0].good) == LOCK_RUNS - 3'h1)
    else $error("lock rose before five good cycles");

  chk_lock_drop: assert property ( // RL16
    on[0] && r_reg.ch[0].on && !rst[0] && ev[0]
      && r_reg.ch[0].err > ERR_OUT_CYC
    |=> !r_reg.ch[0].lock)
    else $error("lock held after large phase error");

  chk_polarity_swap: assert property ( // RL9
    on[1] && r_reg.ch[1].on && !rst[1] && !pol[1]
      && r_reg.ch[1].up && !r_reg.ch[1].dn
    |=> r_reg.ch[1].pd && !r_reg.ch[1].pu)
    else $error("negative polarity did not swap pump");

  chk_doubler_ref: assert property ( // RL11
    r_reg.rfr.dbl |=> r_reg.ref_on)
    else $error("reference block off with doubler set");

  chk_frac_swallow: assert property ( // RL6
    on[0] && npul[0] && frac_sum >= frac_mod
    |=> r_reg.ovf ##0 ndiv[0] == r_reg.rfn.n_int + 15'h0001)
    else $error("overflow did not add a cycle");

  cov_lock_gained: cover property (
    !r_reg.ch[0].lock ##1 r_reg.ch[0].lock && r_reg.ch[0].on);
  cov_preset_latch: cover property (
    le_rise && r_reg.sr[2:0] == ADDR_PRESET);
  cov_swallow: cover property (
    npul[0] ##1 r_reg.ovf);
  cov_analog_low: cover property (
    r_reg.ifr.ld_sel == LK_ANALOG && r_reg.lk_oe);
  cov_lock_lost: cover property (
    r_reg.ch[0].lock ##1 !r_reg.ch[0].lock && r_reg.ch[0].on);

endmodule // tsd_core

// File: verif/tsd_host.sv
// host-side model of the three-wire programming port
// assumes sys_clk at 40 MHz paces the 200 ns serial clock
`timescale 1ns/1ps
module tsd_host (
  input wire logic sys_clk,
  output logic ser_clk,
  output logic ser_data,
  output logic latch_enable
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_enable = 1'b1;
  end

  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask

  // one rising serial clock, data set up half a period ahead
  task automatic bit_out(input logic b);
    ser_data = b;
    half();
    ser_clk = 1'b1;
    half();
    ser_clk = 1'b0;
  endtask

  task automatic send_word(input logic [31:0] w);
    latch_enable = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      bit_out(w[i]);
    end
    ser_data = ~w[0]; // released line shows no stale value
    half();
    latch_enable = 1'b1;
    half();
  endtask

  // clocks while latch is high, commanded as a misuse
  task automatic stray_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      bit_out(1'b0);
    end
  endtask

  // latch pulse with no clocks: re-copies the shift register
  task automatic relatch();
    latch_enable = 1'b0;
    half();
    latch_enable = 1'b1;
    half();
  endtask
endmodule // tsd_host

// File: verif/tsd_core_tb.sv
// self-checking bench of the synth divider core
// assumes tsd_host drives the serial port; feedback follows reference
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); fail_count++; end end
module tsd_core_tb import tsd_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic ref_in = 1'b0;
  logic ref_run = 1'b0;
  logic [2:0] en = 3'b111;
  logic ser_clk, ser_data, latch_enable;
  logic [NCH-1:0] up, dn, oe;
  tsd_icp_e icp;
  logic dbl_o, ref_on, band_o, lock_out, lock_oe;
  int fail_count = 0;
  int checked = 0;
  int seed = 99;
  logic [2:0] rv;
  logic lk0;
  logic [2:0] fb = 3'b000;
  logic fb_run = 1'b0;
  int lk_n;
  // one comparison period: 80 reference falls, 8 clocks apart
  localparam int CMP_CYC = 640;

  always #12.5 sys_clk = ~sys_clk;

  initial forever begin
    repeat (4) @(negedge sys_clk);
    if (ref_run) ref_in = ~ref_in;
    // feedback rises where reference falls: aligned dividers
    fb = fb_run ? {3{~ref_in}} : 3'b000;
  end

  tsd_host i_host (.sys_clk(sys_clk), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_enable(latch_enable));

  tsd_core i_dut (.sys_clk(sys_clk), .reset(reset), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_enable(latch_enable), .ref_in(ref_in),
    .main_fb_in(fb[0]), .recv_fb_in(fb[1]), .xmit_fb_in(fb[2]),
    .main_enable_pin(en[0]), .recv_enable_pin(en[1]),
    .xmit_enable_pin(en[2]), .pump_output_up(up), .pump_output_dn(dn),
    .pump_output_oe(oe), .main_pump_current_sel(icp),
    .doubler_on(dbl_o), .ref_block_on(ref_on), .main_high_band(band_o),
    .lock_out(lock_out), .lock_oe(lock_oe));

  function automatic logic [31:0] rfr_w(logic [1:0] c, logic d, logic p,
    logic [7:0] rc = 8'h00);
    tsd_rfr_s v;
    v = RFR_PRESET;
    if (rc != 8'h00) v.r_cnt = rc;
    v.icpo = tsd_icp_e'(c);
    v.dbl = d;
    v.pol = p;
    return {v, ADDR_RFR};
  endfunction

  function automatic logic [31:0] rfn_w(logic b, logic pw,
    logic [3:0] nf = 4'h0);
    tsd_rfn_s v;
    v = RFN_PRESET;
    v.n_frac = nf;
    v.high_band = b;
    v.pwdn = pw;
    return {v, ADDR_RFN};
  endfunction

  function automatic logic [31:0] ifn_w(logic pw);
    tsd_ifn_s v;
    v = IFN_PRESET;
    v.xmit_powerdown_bit = pw;
    v.recv_powerdown_bit = pw;
    return {v, ADDR_IFN};
  endfunction

  function automatic logic [31:0] ifr_w(tsd_lock_e s, logic p);
    tsd_ifr_s v;
    v = IFR_PRESET;
    v.ld_sel = s;
    v.rx_pol = p;
    v.tx_pol = p;
    return {v, ADDR_IFR};
  endfunction

  task automatic settle();
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wait_oe();
    int n;
    n = 0;
    while (oe[0] !== 1'b1 && n < 800) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 800) begin
      $display("MISMATCH pump_wait exp 1 got 0");
      fail_count++;
      report_and_stop();
    end
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    settle();
    // every current code, random doubler and band
    for (int i = 0; i < 8; i++) begin
      rv = 3'($random(seed));
      i_host.send_word(rfr_w(2'(i), rv[0], 1'b1));
      i_host.send_word(rfn_w(rv[1], 1'b0));
      settle();
      `CHK("pump_current", tsd_icp_e'(2'(i)), icp)
      `CHK("doubler", rv[0], dbl_o)
      `CHK("high_band", rv[1], band_o)
    end
    $display("test bank writes done");
    i_host.send_word(32'h0000_0000);
    settle();
    `CHK("preset_icp", ICP_100UA, icp)
    `CHK("preset_dbl", 1'b0, dbl_o)
    `CHK("preset_band", 1'b1, band_o)
    $display("test preset done");
    // stray clocks would turn the address into the preset one
    i_host.send_word(rfr_w(2'h2, 1'b1, 1'b1));
    i_host.stray_clocks(3);
    i_host.relatch();
    settle();
    `CHK("stray_icp", ICP_700UA, icp)
    `CHK("stray_dbl", 1'b1, dbl_o)
    $display("test stray clocks done");
    for (int i = 0; i < 8; i++) begin
      rv = 3'($random(seed));
      en = (i == 0) ? 3'b000 : rv;
      i_host.send_word(rfr_w(2'h0, rv[0] ^ rv[2], 1'b1));
      settle();
      `CHK("ref_block", (rv[0] ^ rv[2]) | (|en), ref_on)
    end
    en = 3'b111;
    i_host.send_word(rfr_w(2'h0, 1'b0, 1'b1));
    i_host.send_word(ifn_w(1'b1));
    i_host.send_word(rfn_w(1'b1, 1'b1));
    settle();
    `CHK("ref_all_pwdn", 1'b0, ref_on)
    i_host.send_word(32'h0000_0000);
    $display("test power done");
    rv = 3'($random(seed));
    i_host.send_word(rfr_w(2'h0, 1'b0, rv[0]));
    ref_run = 1'b1;
    wait_oe();
    settle();
    `CHK("pump_up", rv[0], up[0])
    `CHK("pump_dn", ~rv[0], dn[0])
    i_host.send_word(ifr_w(LK_ANALOG, 1'b0));
    settle();
    `CHK("analog_lock", 1'b1, lock_oe)
    `CHK("recv_swap", 2'b01, {up[1], dn[1]})
    i_host.send_word(ifr_w(LK_MAIN_R, 1'b1));
    settle();
    lk0 = lock_out;
    for (int n = 0; n < 400 && lock_out === lk0; n++) begin
      @(negedge sys_clk);
    end
    `CHK("counter_mux", ~lk0, lock_out)
    `CHK("counter_drive", 1'b1, lock_oe)
    if (lock_out === lk0) report_and_stop();
    en[0] = 1'b0;
    settle();
    `CHK("off_oe", 1'b0, oe[0])
    `CHK("off_pumps", 2'b00, {up[0], dn[0]})
    $display("test pumps done");
    // aux channels down, main R and N both 80 on one edge stream
    i_host.send_word(ifn_w(1'b1));
    i_host.send_word(rfr_w(2'h0, 1'b0, 1'b1, 8'h50));
    i_host.send_word(ifr_w(LK_DIGITAL, 1'b1));
    fb_run = 1'b1;
    en[0] = 1'b1;
    settle();
    `CHK("unlocked", 1'b1, lock_oe)
    lk_n = 8;
    while (lock_oe !== 1'b0 && lk_n < 6 * CMP_CYC) begin
      @(negedge sys_clk);
      lk_n++;
    end
    `CHK("lock_gain", 1'b0, lock_oe)
    `CHK("lock_delay", 1'b1, lk_n >= 5 * CMP_CYC - 16)
    if (lock_oe !== 1'b0) report_and_stop();
    // numerator with modulus one swallows a cycle every period
    i_host.send_word(rfn_w(1'b1, 1'b0, 4'h1));
    lk_n = 0;
    while (lock_oe !== 1'b1 && lk_n < 3 * CMP_CYC) begin
      @(negedge sys_clk);
      lk_n++;
    end
    `CHK("lock_loss", 1'b1, lock_oe)
    $display("test lock done");
    report_and_stop();
  end
endmodule // tsd_core_tb
